// ===== verilog/aespi_defines.vh
/*
 * Constants for the angle encoder serial port: frame layout, commands,
 * register addresses and reset values, and timing of the angle source.
 * Assumes a 20 MHz system clock.
 */
`ifndef AESPI_DEFINES_VH
`define AESPI_DEFINES_VH

`define AESPI_CLK_HZ 20000000
`define AESPI_FRAME_BITS 16
`define AESPI_CNT_W 5
`define AESPI_CMD_READ 3'h2
`define AESPI_CMD_WRITE 3'h4
`define AESPI_ADDR_W 5
`define AESPI_REG_ZERO_LO 5'h00
`define AESPI_REG_ZERO_HI 5'h01
`define AESPI_REG_THRESH 5'h06
`define AESPI_REG_DIR 5'h09
`define AESPI_REG_FLAGS 5'h1B
`define AESPI_RST_ZERO_LO 8'h00
`define AESPI_RST_ZERO_HI 8'h00
`define AESPI_RST_THRESH 8'h1C
`define AESPI_RST_DIR 8'h00
`define AESPI_DIR_BIT 7
`define AESPI_FE_RATE_HZ 1000000
`define AESPI_FE_DIV (`AESPI_CLK_HZ / `AESPI_FE_RATE_HZ)
`define AESPI_FE_DIV_W 5
`define AESPI_ANGLE_W 16
`define AESPI_OUT_BITS 8
`define AESPI_CUTOFF_HZ 90
`define AESPI_TAU_NUM_X100 38
`define AESPI_FILT_SHIFT 11

`endif

// ===== verilog/aespi_slave.v
/*
 * Serial port of a magnetic angle encoder, with its angle source:
 * a 1 MHz front-end sample strobe, a smoothing filter, zero offset and
 * direction, and the configuration registers reached through the port.
 * Assumes csn, sclk and mosi come from a foreign clock domain; miso is
 * returned as data plus output enable, the board resolves the wire.
 */
`timescale 1ns/1ps
`include "aespi_defines.vh"

module aespi_slave (
  input wire clk_i,
  input wire rst_n_i,
  input wire [15:0] raw_angle_i,
  input wire mag_high_i,
  input wire mag_low_i,
  input wire spi_csn_i,
  input wire spi_sclk_i,
  input wire spi_mosi_i,
  output wire spi_miso_o,
  output wire spi_miso_oe_o,
  output wire [15:0] angle_o,
  output wire fe_strobe_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [1:0] cs_sync_q;
  reg [1:0] ck_sync_q;
  reg [1:0] mo_sync_q;
  reg cs_prev_q;
  reg ck_prev_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_sync_q <= 2'h3;
      ck_sync_q <= 2'h0;
      mo_sync_q <= 2'h0;
      cs_prev_q <= 1'b1;
      ck_prev_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], spi_csn_i};
      ck_sync_q <= {ck_sync_q[0], spi_sclk_i};
      mo_sync_q <= {mo_sync_q[0], spi_mosi_i};
      cs_prev_q <= cs_sync_q[1];
      ck_prev_q <= ck_sync_q[1];
    end
  end

  wire csn = cs_sync_q[1];
  wire cs_fall = cs_prev_q & ~csn;
  wire cs_rise = ~cs_prev_q & csn;
  // Edge detect on the sampled clock makes mode 0 and mode 3 look alike
  wire ck_rise = ~csn & ~ck_prev_q & ck_sync_q[1];
  wire ck_fall = ~csn & ck_prev_q & ~ck_sync_q[1];

  // ****************************************
  // Front-end strobe, filter, zero and direction
  // ****************************************
  reg [`AESPI_FE_DIV_W-1:0] fe_div_q;
  reg fe_stb_q;
  reg [31:0] stage1_q;
  reg [31:0] stage2_q;
  reg [15:0] angle_q;
  reg [15:0] raw_q;
  wire fe_wrap = (fe_div_q == (`AESPI_FE_DIV - 1));

  // Wrap-aware error so a 0/360 crossing does not kick the filter
  function [31:0] ang_err;
    input [15:0] target;
    input [31:0] state;
    reg [15:0] diff;
    begin
      diff = target - state[31:16];
      ang_err = {{16{diff[15]}}, diff} << (16 - `AESPI_FILT_SHIFT);
    end
  endfunction

  // Configuration registers
  reg [7:0] zero_lo_q;
  reg [7:0] zero_hi_q;
  reg [7:0] thresh_q;
  reg [7:0] dir_q;

  wire [31:0] err1 = ang_err(raw_q, stage1_q);
  wire [31:0] err2 = ang_err(stage1_q[31:16], stage2_q);
  // Feed-forward term is signed; halve it keeping the sign bit
  wire [31:0] err_dif = err1 - err2;
  wire [15:0] zeroed = stage2_q[31:16] + {zero_hi_q, zero_lo_q};
  wire [15:0] oriented = dir_q[`AESPI_DIR_BIT] ? (16'h0000 - zeroed) : zeroed;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fe_div_q <= {`AESPI_FE_DIV_W{1'b0}};
      fe_stb_q <= 1'b0;
      raw_q <= 16'h0000;
      stage1_q <= 32'h00000000;
      stage2_q <= 32'h00000000;
      angle_q <= 16'h0000;
    end else begin
      fe_div_q <= fe_wrap ? {`AESPI_FE_DIV_W{1'b0}} : fe_div_q + 1'b1;
      fe_stb_q <= fe_wrap;
      if (fe_wrap) begin
        raw_q <= raw_angle_i;
      end
      if (fe_stb_q) begin
        // Two cascaded first-order sections plus error feed-forward of the
        // second makes the zero; ramps settle with a steady lag
        stage1_q <= stage1_q + err1 + {err_dif[31], err_dif[31:1]};
        stage2_q <= stage2_q + err2;
        angle_q <= oriented;
      end
    end
  end

  assign angle_o = angle_q;
  assign fe_strobe_o = fe_stb_q;

  // ****************************************
  // Frame shifter and command decode
  // ****************************************
  reg [`AESPI_CNT_W-1:0] bit_cnt_q;
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg miso_q;
  reg pend_q;
  reg [7:0] pend_val_q;

  function [7:0] reg_read;
    input [4:0] addr;
    input [7:0] zl;
    input [7:0] zh;
    input [7:0] th;
    input [7:0] dr;
    input [1:0] flags;
    begin
      case (addr)
        `AESPI_REG_ZERO_LO: reg_read = zl;
        `AESPI_REG_ZERO_HI: reg_read = zh;
        `AESPI_REG_THRESH: reg_read = th;
        `AESPI_REG_DIR: reg_read = dr;
        `AESPI_REG_FLAGS: reg_read = {flags, 6'h00};
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  wire [15:0] rx_word = {rx_q[14:0], mo_sync_q[1]};
  // Only the top output bits carry angle; the rest of the word goes out as zero
  wire [15:0] angle_tx = angle_q & ~(16'hFFFF >> `AESPI_OUT_BITS);
  wire frame_done = ck_rise & (bit_cnt_q == (`AESPI_FRAME_BITS - 1));
  wire [2:0] cmd = rx_word[15:13];
  wire [4:0] addr = rx_word[12:8];
  wire is_wr = frame_done & (cmd == `AESPI_CMD_WRITE);
  wire is_rd = frame_done & (cmd == `AESPI_CMD_READ);
  wire [7:0] rd_val = reg_read(addr, zero_lo_q, zero_hi_q, thresh_q, dir_q,
                               {mag_high_i, mag_low_i});

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_q <= {`AESPI_CNT_W{1'b0}};
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      miso_q <= 1'b0;
      pend_q <= 1'b0;
      pend_val_q <= 8'h00;
      zero_lo_q <= `AESPI_RST_ZERO_LO;
      zero_hi_q <= `AESPI_RST_ZERO_HI;
      thresh_q <= `AESPI_RST_THRESH;
      dir_q <= `AESPI_RST_DIR;
    end else begin
      if (cs_fall) begin
        bit_cnt_q <= {`AESPI_CNT_W{1'b0}};
        // Answer to the previous command, else the angle snapshot
        if (pend_q) begin
          tx_q <= {pend_val_q, 8'h00};
          miso_q <= pend_val_q[7];
        end else begin
          tx_q <= angle_tx;
          miso_q <= angle_tx[15];
        end
        pend_q <= 1'b0;
      end else if (ck_rise) begin
        rx_q <= rx_word;
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end else if (ck_fall && bit_cnt_q != {`AESPI_CNT_W{1'b0}}) begin
        // Next bit after each falling edge once a rising edge has been counted; zeros fill past the word
        tx_q <= {tx_q[14:0], 1'b0};
        miso_q <= tx_q[14];
      end
      if (is_wr) begin
        pend_q <= 1'b1;
        pend_val_q <= rx_word[7:0];
        case (addr)
          `AESPI_REG_ZERO_LO: zero_lo_q <= rx_word[7:0];
          `AESPI_REG_ZERO_HI: zero_hi_q <= rx_word[7:0];
          `AESPI_REG_THRESH: thresh_q <= rx_word[7:0];
          `AESPI_REG_DIR: dir_q <= rx_word[7:0];
          default: pend_val_q <= 8'h00;
        endcase
      end else if (is_rd) begin
        pend_q <= 1'b1;
        pend_val_q <= rd_val;
      end else if (cs_rise && bit_cnt_q != `AESPI_FRAME_BITS) begin
        pend_q <= 1'b0; // Frame of other than 16 bits: no answer queued; a longer frame has still written its register at bit 16
      end
    end
  end

  assign spi_miso_o = miso_q;
  assign spi_miso_oe_o = ~csn;

endmodule

// ===== testbench/aespi_monitor.sv
/* Checker on the encoder port pins and angle outputs.
   Assumes a single clk_i domain; bound to every aespi_slave. */
`timescale 1ns/1ps
module aespi_monitor (
  input wire clk_i,
  input wire rst_n_i,
  input wire spi_csn_i,
  input wire spi_sclk_i,
  input wire spi_miso_o,
  input wire spi_miso_oe_o,
  input wire [15:0] angle_o,
  input wire fe_strobe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_oe_on_select: assert property ($fell(spi_csn_i) |-> ##[1:4] spi_miso_oe_o)
    else $error("oe late");
  a_oe_off_release: assert property ($rose(spi_csn_i) |-> ##[1:4] !spi_miso_oe_o)
    else $error("oe held");
  a_oe_idle_low: assert property (spi_csn_i [*5] |-> !spi_miso_oe_o)
    else $error("oe in idle");
  // Sync delay lets a change trail the falling edge by up to four cycles
  a_miso_on_fall: assert property ($changed(spi_miso_o) && spi_miso_oe_o && !spi_csn_i
    && !$past(spi_csn_i, 4) |-> !spi_sclk_i) else $error("miso moved, clock high");
  a_strobe_period: assert property (fe_strobe_o |-> ##20 fe_strobe_o)
    else $error("strobe period");
  a_strobe_gap: assert property (fe_strobe_o |=> !fe_strobe_o [*8])
    else $error("strobe early");
  a_strobe_late_gap: assert property (fe_strobe_o ##9 1 |-> !fe_strobe_o [*8])
    else $error("strobe early");
  a_angle_on_strobe: assert property (!$stable(angle_o) |-> $past(fe_strobe_o))
    else $error("angle moved off strobe");
endmodule
bind aespi_slave aespi_monitor i_aespi_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .spi_csn_i(spi_csn_i), .spi_sclk_i(spi_sclk_i), .spi_miso_o(spi_miso_o),
  .spi_miso_oe_o(spi_miso_oe_o), .angle_o(angle_o), .fe_strobe_o(fe_strobe_o));

// ===== testbench/aespi_host.sv
/* Behavioural SPI host for the encoder port.
   Assumes the bench clk_i; link clock of 8 clk_i (400 ns), still between frames. */
`timescale 1ns/1ps
module aespi_host (
  input wire clk_i,
  input wire miso_i,
  output reg csn_o,
  output reg sclk_o,
  output reg mosi_o
);
  integer i;
  initial begin
    csn_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // Idle clock level selects the mode
  task xfer(input reg m3, input reg [15:0] tx, output reg [15:0] rx);
    begin
      @(posedge clk_i) sclk_o <= m3;
      repeat (4) @(posedge clk_i);
      csn_o <= 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b0;
        mosi_o <= tx[i];
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b1;
        rx[i] = miso_i;
      end
      repeat (4) @(posedge clk_i);
      sclk_o <= m3;
      repeat (2) @(posedge clk_i);
      csn_o <= 1'b1;
      mosi_o <= 1'b0; // Pull-down once released
      repeat (16) @(posedge clk_i);
    end
  endtask
endmodule

// ===== testbench/testbench.sv
/* Self-checking bench for the encoder serial port.
   Assumes aespi_host as partner and a pull-down on the data-out wire. */
`timescale 1ns/1ps
`include "aespi_defines.vh"
module testbench;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [15:0] raw_angle_i = 16'h0000;
  reg mag_high_i = 1'b0;
  reg mag_low_i = 1'b0;
  wire csn, sclk, mosi, miso, miso_oe, strobe;
  wire [15:0] angle;
  wire miso_w = miso_oe ? miso : 1'b0;
  integer error_cnt = 0, cmp_count = 0, cyc = 0, n, k;
  reg [15:0] rx;
  reg [7:0] v;
  reg [15:0] ea;
  reg rnd_on = 1'b0;
  reg [31:0] regs;
  reg [19:0] ads;
  aespi_slave i_aespi_slave (.clk_i(clk_i), .rst_n_i(rst_n_i), .raw_angle_i(raw_angle_i),
    .mag_high_i(mag_high_i), .mag_low_i(mag_low_i), .spi_csn_i(csn), .spi_sclk_i(sclk),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .angle_o(angle),
    .fe_strobe_o(strobe));
  aespi_host i_aespi_host (.clk_i(clk_i), .miso_i(miso_w), .csn_o(csn), .sclk_o(sclk),
    .mosi_o(mosi));
  initial forever #25 clk_i = ~clk_i;
  task give_verdict;
    begin
      $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
    end
  endtask
  function [15:0] resp_of(input [7:0] val);
    resp_of = {val, 8'h00};
  endfunction
  // Streamed angle with the front-end at zero: the zero setting, negated when reversed
  function [15:0] exp_angle(input [15:0] z, input rd);
    exp_angle = rd ? (16'h0000 - z) : z;
  endfunction
  // Command frame, then a filler frame that carries the answer
  // No store wait after a write: the model commits at once, 20 ms would outrun the bench
  task reg_op(input [2:0] cmd, input [4:0] ad, input [7:0] val);
    begin
      i_aespi_host.xfer(1'($urandom), {cmd, ad, val}, rx);
      i_aespi_host.xfer(1'($urandom), 16'h0000, rx);
    end
  endtask
  // ****************************************
  // Stimulus and timeout
  // ****************************************
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    raw_angle_i <= rnd_on ? 16'($urandom) : 16'h0000;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  initial begin
    k = $urandom(72368);
    ads = {`AESPI_REG_DIR, `AESPI_REG_THRESH, `AESPI_REG_ZERO_HI, `AESPI_REG_ZERO_LO};
    regs = {`AESPI_RST_DIR, `AESPI_RST_THRESH, `AESPI_RST_ZERO_HI, `AESPI_RST_ZERO_LO};
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (n = 0; n < 4; n = n + 1) begin
      reg_op(`AESPI_CMD_READ, ads[n*5 +: 5], 8'h00);
      check(rx, resp_of(regs[n*8 +: 8]));
    end
    // Front-end held at zero keeps the filter at rest, so the angle is exact
    for (n = 0; n < 2; n = n + 1) begin
      for (k = 0; k < 4; k = k + 1) begin
        v = (k == 3) ? {n[0], 7'h00} : 8'($urandom);
        reg_op(`AESPI_CMD_WRITE, ads[k*5 +: 5], v);
        check(rx, resp_of(v));
        regs[k*8 +: 8] = v;
      end
      i_aespi_host.xfer(1'($urandom), 16'h0000, rx);
      ea = exp_angle(regs[15:0], regs[31]);
      check(angle, ea);
      check(rx, ea & ~(16'hFFFF >> `AESPI_OUT_BITS));
    end
    rnd_on <= 1'b1;
    for (n = 0; n < 14; n = n + 1) begin
      k = $urandom % 4;
      v = (n < 2) ? {8{n == 0}} : 8'($urandom);
      mag_high_i <= 1'($urandom);
      mag_low_i <= 1'($urandom);
      reg_op(`AESPI_CMD_WRITE, ads[k*5 +: 5], v);
      check(rx, resp_of(v));
      regs[k*8 +: 8] = v;
      reg_op(`AESPI_CMD_READ, ads[k*5 +: 5], 8'h00);
      check(rx, resp_of(regs[k*8 +: 8]));
      reg_op(`AESPI_CMD_READ, `AESPI_REG_FLAGS, 8'h00);
      check(rx, resp_of({mag_high_i, mag_low_i, 6'h00}));
    end
    reg_op(`AESPI_CMD_WRITE, 5'h1F, 8'hA5);
    check(rx, 16'h0000);
    give_verdict;
  end
endmodule
